// ===== include/rsoca_pkg.sv
// Constants and types for the overhead channel adapter
package rsoca_pkg;

    // ****************************************
    // Frame geometry
    // ****************************************
    localparam int ROW_BYTES = 1080;               // Bytes per row of an STM-4 frame
    localparam int ROWS = 9;                        // Rows per frame
    localparam int FRAME_BYTES = ROW_BYTES * ROWS;  // 9720 bytes per 125 us frame
    localparam int E1_COL = 12;                     // Column offset of E1 in row two
    localparam int F1_COL = 24;                     // Column offset of F1 in row two
    localparam int E1_POS = ROW_BYTES + E1_COL;     // Byte index of E1 in the frame
    localparam int F1_POS = ROW_BYTES + F1_COL;     // Byte index of F1 in the frame

    // ****************************************
    // 64 kHz derivation
    // ****************************************
    localparam int OCTET_W = 8;                     // Bits per overhead octet
    localparam int LINE_DIV = 9720;                 // Line bit clock divisor for 64 kHz
    localparam int BIT_BYTES = LINE_DIV / OCTET_W;  // Byte strobes per 64 kHz period
    localparam int HALF_BYTES = BIT_BYTES / 2;      // Low phase length of the 64 kHz clock

    localparam int POS_W = 14;                      // Frame position counter width
    localparam int SUB_W = 11;                      // Sub-bit counter width
    localparam int BIT_W = 3;                       // Bit index width

    localparam logic [POS_W-1:0] POS_LAST = POS_W'(FRAME_BYTES - 1);
    localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(BIT_BYTES - 1);
    localparam logic [SUB_W-1:0] SUB_HALF = SUB_W'(HALF_BYTES);
    localparam logic [OCTET_W-1:0] ALL_ONES = 8'hFF;
    localparam logic [OCTET_W-1:0] OCTET_RST = 8'hFF;

    // Orderwire byte choice
    typedef enum logic {
        RSOCA_SEL_E1 = 1'b0,
        RSOCA_SEL_F1 = 1'b1
    } rsoca_sel_t;

    // Position within the frame and within a 64 kHz bit
    typedef struct packed {
        logic [POS_W-1:0] pos;
        logic [SUB_W-1:0] sub;
        logic [BIT_W-1:0] bit_idx;
    } rsoca_tim_t;

    localparam rsoca_tim_t TIM_RST = '{pos: '0, sub: '0, bit_idx: '0};

endpackage

// ===== core/rsoca_top.sv
// Overhead channel adapter: orderwire and user channel sinks, user channel source
`timescale 1ns/1ps
// Summary of operation
// - Orderwire taken from E1 or F1, parameter-selected
// - Received octet latched in store on line clock
// - Stored bits shifted out at line/9720 rate
// - Orderwire all-ones within 1 ms on fail
// - Orderwire normal data within 1 ms after clear
// - User channel source inserts data into F1
// - User channel sink extracts F1, with clock
// - User sink all-ones on fail, restores after
module rsoca_top #(
    parameter rsoca_pkg::rsoca_sel_t OW_SEL = rsoca_pkg::RSOCA_SEL_E1  // Orderwire byte
) (
    input wire logic sys_clk,                          // 200 MHz block clock
    input wire logic sys_rst,                          // Synchronous reset, active high
    input wire logic clk_en,                           // Freezes all state while low
    input wire logic [7:0] rx_byte,                    // Received line byte
    input wire logic rx_byte_valid,                    // Received line byte strobe
    input wire logic rx_frame_start,                   // First byte of received frame
    input wire logic trail_signal_fail_in,             // Trail signal fail from termination
    output logic orderwire_channel_data,               // Orderwire serial data
    output logic orderwire_out_clock,                  // Orderwire 64 kHz clock
    output logic orderwire_server_fail_out,            // Orderwire server fail
    output logic user_channel_data,                    // User channel sink serial data
    output logic user_channel_sink_clock,              // User channel sink 64 kHz clock
    output logic user_server_fail_out,                 // User channel server fail
    input wire logic [7:0] tx_byte,                    // Outgoing line byte before insertion
    input wire logic line_timing_clock,                // Outgoing byte strobe
    input wire logic line_timing_frame_start,          // First byte of outgoing frame
    input wire logic user_channel_in,                  // Client user channel data
    output logic user_channel_clock,                   // 64 kHz clock to source client
    output logic [7:0] tx_byte_out,                    // Outgoing byte after insertion
    output logic tx_byte_out_valid                     // Outgoing byte strobe
);

    // ****************************************
    // Receive timing
    // ****************************************
    rsoca_pkg::rsoca_tim_t rx_tim_d, rx_tim_q;         // Receive frame and bit position
    logic bit_edge;                                    // Start of a 64 kHz bit period

    // Advance the timing on each byte strobe; frame start realigns all
    function automatic rsoca_pkg::rsoca_tim_t rsoca_tim_next(
        input rsoca_pkg::rsoca_tim_t t,
        input logic strobe,
        input logic fs
    );
        rsoca_pkg::rsoca_tim_t n;
        n = t;
        if (strobe && fs) begin
            // Frame start byte is position zero
            n = rsoca_pkg::TIM_RST;
        end else if (strobe) begin
            // Frame position wraps after the last byte
            n.pos = (t.pos == rsoca_pkg::POS_LAST) ? '0 : t.pos + rsoca_pkg::POS_W'(1);
            if (t.sub == rsoca_pkg::SUB_LAST) begin
                // End of a 64 kHz bit: move to the next bit index
                n.sub = '0;
                n.bit_idx = t.bit_idx + rsoca_pkg::BIT_W'(1);
            end else begin
                // Still inside the bit period
                n.sub = t.sub + rsoca_pkg::SUB_W'(1);
            end
        end
        return n;
    endfunction

    // Next receive position
    always_comb begin
        rx_tim_d = rsoca_tim_next(rx_tim_q, rx_byte_valid, rx_frame_start);
    end

    // Register receive position
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_tim_q <= rsoca_pkg::TIM_RST;
        end else if (clk_en) begin
            rx_tim_q <= rx_tim_d;
        end
    end

    assign bit_edge = rx_byte_valid && (rx_tim_q.sub == rsoca_pkg::SUB_LAST);

    // ****************************************
    // Sink channels: 0 orderwire, 1 user
    // ****************************************
    localparam int unsigned CH_POS [2] = '{
        (OW_SEL == rsoca_pkg::RSOCA_SEL_F1) ? rsoca_pkg::F1_POS : rsoca_pkg::E1_POS,
        rsoca_pkg::F1_POS
    };

    logic [1:0] sk_data;                               // Serial data per channel
    logic [1:0] sk_clk;                                // 64 kHz clock per channel
    logic [1:0] sk_fail;                               // Server fail per channel

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_sink
            logic [7:0] hold_d, hold_q;                // Latched overhead octet
            logic [7:0] shift_d, shift_q;              // Octet being shifted out
            logic data_d, data_q;                      // Output bit
            logic clk_d, clk_q;                        // Output clock
            logic fail_d, fail_q;                      // Server fail

            // Capture, smoothing and fail substitution
            always_comb begin
                hold_d = hold_q;
                shift_d = shift_q;
                // The next position value is the index of the byte now on the bus
                if (rx_byte_valid && (rx_tim_d.pos == rsoca_pkg::POS_W'(CH_POS[ch]))) begin
                    hold_d = rx_byte;
                end
                if (bit_edge) begin
                    // Octet boundary each frame reloads from the store
                    if (rx_tim_q.bit_idx == rsoca_pkg::BIT_W'(rsoca_pkg::OCTET_W - 1)) begin
                        shift_d = hold_q;
                    end else begin
                        shift_d = {shift_q[6:0], 1'b1};
                    end
                end
                clk_d = (rx_tim_d.sub >= rsoca_pkg::SUB_HALF);
                fail_d = trail_signal_fail_in;
                // Fail forces ones and clear restores data, both on the next cycle
                data_d = trail_signal_fail_in ? 1'b1 : shift_d[7];
            end

            // Register sink state
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    hold_q <= rsoca_pkg::OCTET_RST;
                    shift_q <= rsoca_pkg::OCTET_RST;
                    data_q <= 1'b1;
                    clk_q <= 1'b0;
                    fail_q <= 1'b0;
                end else if (clk_en) begin
                    hold_q <= hold_d;
                    shift_q <= shift_d;
                    data_q <= data_d;
                    clk_q <= clk_d;
                    fail_q <= fail_d;
                end
            end

            assign sk_data[ch] = data_q;
            assign sk_clk[ch] = clk_q;
            assign sk_fail[ch] = fail_q;
        end
    endgenerate

    assign orderwire_channel_data = sk_data[0];
    assign orderwire_out_clock = sk_clk[0];
    assign orderwire_server_fail_out = sk_fail[0];
    assign user_channel_data = sk_data[1];
    assign user_channel_sink_clock = sk_clk[1];
    assign user_server_fail_out = sk_fail[1];

    // ****************************************
    // User channel source
    // ****************************************
    rsoca_pkg::rsoca_tim_t tx_tim_d, tx_tim_q;         // Outgoing frame and bit position
    logic [7:0] src_shift_d, src_shift_q;              // Octet assembled from client
    logic [7:0] src_hold_d, src_hold_q;                // Complete octet awaiting F1
    logic src_clk_d, src_clk_q;                        // Client clock
    logic [7:0] out_d, out_q;                          // Outgoing byte
    logic out_vld_d, out_vld_q;                        // Outgoing strobe
    logic samp;                                        // Client clock rising point

    // Next source values
    always_comb begin
        tx_tim_d = rsoca_tim_next(tx_tim_q, line_timing_clock, line_timing_frame_start);
        samp = line_timing_clock && (tx_tim_q.sub == rsoca_pkg::SUB_HALF - rsoca_pkg::SUB_W'(1));
        src_shift_d = src_shift_q;
        src_hold_d = src_hold_q;
        // Sample client bit as its clock rises
        if (samp) begin
            src_shift_d = {src_shift_q[6:0], user_channel_in};
            if (tx_tim_q.bit_idx == rsoca_pkg::BIT_W'(rsoca_pkg::OCTET_W - 1)) begin
                src_hold_d = {src_shift_q[6:0], user_channel_in};
            end
        end
        // Client clock rises mid-bit and falls at the bit boundary
        src_clk_d = (tx_tim_d.sub >= rsoca_pkg::SUB_HALF);
        // Outgoing strobe follows the byte by one cycle
        out_vld_d = line_timing_clock;
        // Replace F1, pass everything else
        if (line_timing_clock && (tx_tim_d.pos == rsoca_pkg::POS_W'(rsoca_pkg::F1_POS))) begin
            out_d = src_hold_q;
        end else if (line_timing_clock) begin
            out_d = tx_byte;
        end else begin
            out_d = out_q;
        end
    end

    // Register source state
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_tim_q <= rsoca_pkg::TIM_RST;
            src_shift_q <= rsoca_pkg::OCTET_RST;
            src_hold_q <= rsoca_pkg::OCTET_RST;
            src_clk_q <= 1'b0;
            out_q <= '0;
            out_vld_q <= 1'b0;
        end else if (clk_en) begin
            tx_tim_q <= tx_tim_d;
            src_shift_q <= src_shift_d;
            src_hold_q <= src_hold_d;
            src_clk_q <= src_clk_d;
            out_q <= out_d;
            out_vld_q <= out_vld_d;
        end
    end

    assign user_channel_clock = src_clk_q;
    assign tx_byte_out = out_q;
    assign tx_byte_out_valid = out_vld_q;

endmodule

// ===== test/rsoca_client_model.sv
// User channel client: sends octets, MSB first, on the source clock
`timescale 1ns/1ps
module rsoca_client_model #(
    parameter logic [7:0] FIRST = 8'h5A, // First octet sent
    parameter logic [7:0] STEP = 8'h11 // Added per octet
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic user_channel_clock,
    output logic user_channel_in
);
    logic [7:0] oct_q; // Octet in flight
    logic [2:0] idx_q; // Bit being sent
    logic ck_q; // Clock level one edge ago
    // Bit changes only after the clock falls, so it is steady at the rise
    always @(posedge sys_clk) begin
        ck_q <= user_channel_clock;
        if (sys_rst) begin
            oct_q <= FIRST;
            idx_q <= 3'h0;
        end else if (ck_q && !user_channel_clock) begin
            idx_q <= idx_q + 3'h1;
            oct_q <= (idx_q == 3'h7) ? oct_q + STEP : oct_q;
        end
    end
    assign user_channel_in = oct_q[3'h7 - idx_q];
endmodule

// ===== test/rsoca_top_checker.sv
// Port assertions for the overhead channel adapter
`timescale 1ns/1ps
module rsoca_top_checker (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic trail_signal_fail_in,
    input wire logic orderwire_channel_data,
    input wire logic orderwire_out_clock,
    input wire logic orderwire_server_fail_out,
    input wire logic user_channel_data,
    input wire logic user_server_fail_out,
    input wire logic line_timing_clock,
    input wire logic user_channel_clock,
    input wire logic tx_byte_out_valid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    ow_fail_set_a: assert property (clk_en && trail_signal_fail_in |=> orderwire_server_fail_out)
        else $error("orderwire fail not raised");
    us_fail_clear_a: assert property (clk_en && !trail_signal_fail_in |=> !user_server_fail_out)
        else $error("user fail not cleared");
    ow_ones_a: assert property (clk_en && trail_signal_fail_in |=> orderwire_channel_data)
        else $error("orderwire not all ones");
    uc_ones_a: assert property (clk_en && trail_signal_fail_in |=> user_channel_data)
        else $error("user data not all ones");
    ow_clk_high_a: assert property ($rose(orderwire_out_clock) |-> orderwire_out_clock [*8])
        else $error("orderwire clock high too short");
    ow_data_steady_a: assert property ($rose(orderwire_out_clock) && !$past(trail_signal_fail_in) &&
        !$past(trail_signal_fail_in, 2) && !$past(trail_signal_fail_in, 3) |-> $stable(orderwire_channel_data))
        else $error("orderwire data moved at clock rise");
    uc_clk_high_a: assert property ($rose(user_channel_clock) |-> user_channel_clock [*8])
        else $error("source clock high too short");
    tx_valid_a: assert property (clk_en |=> tx_byte_out_valid == $past(line_timing_clock))
        else $error("outgoing strobe not one cycle late");
    cover property ($rose(trail_signal_fail_in));
    cover property ($rose(orderwire_out_clock));
    cover property ($rose(user_channel_clock));
endmodule
bind rsoca_top rsoca_top_checker chk_u (.sys_clk, .sys_rst, .clk_en, .trail_signal_fail_in, .orderwire_channel_data,
    .orderwire_out_clock, .orderwire_server_fail_out, .user_channel_data, .user_server_fail_out, .line_timing_clock,
    .user_channel_clock, .tx_byte_out_valid);

// ===== test/rs_overhead_channel_adapt_bench.sv
// Self-checking bench for the overhead channel adapter
`timescale 1ns/1ps
module rs_overhead_channel_adapt_bench;
    // ****************************************
    // Frame rows: slot octets in, octets out
    // ****************************************
    typedef struct packed {
        logic [7:0] e1, f1, ow, uc, tx; // Slot inputs, serial outputs, inserted client octet
    } rsoca_row_t;
    localparam rsoca_row_t ROWS [4] = '{'{8'hC3, 8'h3C, 8'hFF, 8'hFF, 8'h00}, '{8'hA5, 8'h0F, 8'hC3, 8'h3C, 8'h5A},
        '{8'h00, 8'hFF, 8'hA5, 8'h0F, 8'h6B}, '{8'h81, 8'h7E, 8'h00, 8'hFF, 8'h7C}};
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1; // Low only in the freeze test
    logic stb = 1'b0; // Byte strobe, both directions
    logic fs = 1'b0; // Frame start, both directions
    logic trail_signal_fail_in = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic [7:0] tx_byte = 8'h00;
    logic orderwire_channel_data, orderwire_out_clock, orderwire_server_fail_out, user_channel_data;
    logic user_channel_sink_clock, user_server_fail_out, user_channel_in, user_channel_clock, tx_byte_out_valid;
    logic [7:0] tx_byte_out;
    int errors = 0;
    int checked = 0;
    always #2.5 sys_clk = ~sys_clk; // 200 MHz
    rsoca_top dut_u (.sys_clk, .sys_rst, .clk_en, .rx_byte, .rx_byte_valid(stb), .rx_frame_start(fs),
        .trail_signal_fail_in, .orderwire_channel_data, .orderwire_out_clock, .orderwire_server_fail_out,
        .user_channel_data, .user_channel_sink_clock, .user_server_fail_out, .tx_byte, .line_timing_clock(stb),
        .line_timing_frame_start(fs), .user_channel_in, .user_channel_clock, .tx_byte_out, .tx_byte_out_valid);
    rsoca_client_model cli_u (.sys_clk, .sys_rst, .user_channel_clock, .user_channel_in);
    // Compare and count
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Drive frame byte i just after the edge
    task automatic step(input int i, input logic [7:0] e1, input logic [7:0] f1);
        @(posedge sys_clk);
        #1;
        stb = 1'b1;
        fs = (i == 0);
        rx_byte = (i == 1092) ? e1 : (i == 1104) ? f1 : 8'(i);
        tx_byte = 8'(i);
    endtask
    // Outputs at their reset levels
    task automatic reset_vals();
        check("ow data", orderwire_channel_data, 8'h01);
        check("uc data", user_channel_data, 8'h01);
        check("ow clock", orderwire_out_clock, 8'h00);
        check("ow fail", orderwire_server_fail_out, 8'h00);
        check("tx byte", tx_byte_out, 8'h00);
        check("tx valid", tx_byte_out_valid, 8'h00);
    endtask
    // Verdict and end of run
    task automatic summarize();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        #1;
        reset_vals();
        sys_rst = 1'b0;
        $display("Test reset done");
        for (int r = 0; r < 4; r++) begin // Frames from the row table
            for (int i = 0; i < 9720; i++) begin
                step(i, ROWS[r].e1, ROWS[r].f1);
                if (i % 1215 == 600) begin // Mid bit, clock low
                    check("ow data", orderwire_channel_data, ROWS[r].ow[7 - i / 1215]);
                    check("uc data", user_channel_data, ROWS[r].uc[7 - i / 1215]);
                    check("ow clock low", orderwire_out_clock, 8'h00);
                    check("uc clock low", user_channel_sink_clock, 8'h00);
                end
                if (i % 1215 == 900) begin // Late bit, clock high
                    check("ow clock high", orderwire_out_clock, 8'h01);
                    check("uc clock high", user_channel_sink_clock, 8'h01);
                end
                if (i == 1105 && r > 0) begin // Slot byte one cycle on
                    check("tx slot", tx_byte_out, ROWS[r].tx);
                end
                if (i == 1104) begin // Byte before the slot passes
                    check("tx pass", tx_byte_out, 8'h4F);
                end
            end
            $display("Test frame %0d done", r);
        end
        for (int i = 0; i < 3000; i++) begin // Fail in bit 1 of a frame
            step(i, 8'h00, 8'h00);
            trail_signal_fail_in = (i >= 2000 && i < 2100);
            if (i == 2001) begin
                check("ow fail set", orderwire_server_fail_out, 8'h01);
                check("uc fail set", user_server_fail_out, 8'h01);
                check("ow ones", orderwire_channel_data, 8'h01);
            end
            if (i == 2101) begin
                check("ow fail clear", orderwire_server_fail_out, 8'h00);
                check("uc fail clear", user_server_fail_out, 8'h00);
                check("ow restored", orderwire_channel_data, 8'h00);
                check("uc restored", user_channel_data, 8'h01);
            end
        end
        $display("Test fail done");
        clk_en = 1'b0; // Freeze: last byte taken is 2998
        step(3000, 8'h00, 8'h00);
        step(3001, 8'h00, 8'h00);
        check("tx frozen", tx_byte_out, 8'hB6);
        check("ow clock frozen", orderwire_out_clock, 8'h00);
        clk_en = 1'b1;
        $display("Test freeze done");
        sys_rst = 1'b1;
        step(3002, 8'h00, 8'h00);
        reset_vals();
        $display("Test mid reset done");
        summarize();
    end
    // Watchdog: the tests need about 42000 cycles
    initial begin
        #300000;
        errors++;
        summarize();
    end
endmodule
